// *** src/adcis_defs.vh ***
`ifndef ADCIS_DEFS_VH
`define ADCIS_DEFS_VH

// Register addresses
`define ADCIS_ADDR_W            8
`define ADCIS_ADDR_IDENT        8'h00
`define ADCIS_ADDR_STATUS       8'h01
`define ADCIS_DATA_W            8

// Identification register layout
`define ADCIS_ID_MODEL_HI       2
`define ADCIS_ID_MODEL_LO       0
`define ADCIS_ID_RSVD_HI        7
`define ADCIS_ID_RSVD_LO        3
// Arbitrary neutral values; the real part straps its own
`define ADCIS_MODEL_CODE_DEF    3'h7
`define ADCIS_ID_RSVD_DEF       5'h00

// Status register bit positions
`define ADCIS_ST_POR            7
`define ADCIS_ST_NOT_READY      6
`define ADCIS_ST_POS_HIGH       5
`define ADCIS_ST_POS_LOW        4
`define ADCIS_ST_NEG_HIGH       3
`define ADCIS_ST_NEG_LOW        2
`define ADCIS_ST_REF_THIRD      1
`define ADCIS_ST_REF_FLOOR      0
`define ADCIS_STATUS_RESET      8'h80

// Reference monitor enable field: one bit per reference flag
`define ADCIS_REFEN_FLOOR       0
`define ADCIS_REFEN_THIRD       1

// Comparator input vector layout
`define ADCIS_CMP_W             6
`define ADCIS_CMP_POS_HIGH      0
`define ADCIS_CMP_POS_LOW       1
`define ADCIS_CMP_NEG_HIGH      2
`define ADCIS_CMP_NEG_LOW       3
`define ADCIS_CMP_REF_THIRD     4
`define ADCIS_CMP_REF_FLOOR     5

`define ADCIS_ZERO8             8'h00

`endif

// *** src/adcis_sync2.v ***
`timescale 1ns/1ps
`default_nettype none

module adcis_sync2 (
    // Clock and reset
    input  wire ref_clk,
    input  wire sys_rst,
    // Level in and out
    input  wire async_in,
    output wire sync_out
);

    reg stage1_q;
    reg stage2_q;

    // First stage feeds only the second stage
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_q <= 1'b0;
            stage2_q <= 1'b0;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;

endmodule

`default_nettype wire

// *** src/adcis_id_status_regs.v ***
`timescale 1ns/1ps
`default_nettype none
`include "adcis_defs.vh"

module adcis_id_status_regs #(
    parameter [2:0] MODEL_CODE = `ADCIS_MODEL_CODE_DEF,
    parameter [4:0] ID_RSVD    = `ADCIS_ID_RSVD_DEF
) (
    // Clock and reset
    input  wire                      ref_clk,
    input  wire                      sys_rst,
    // Register access from the command decoder
    input  wire [`ADCIS_ADDR_W-1:0]  reg_addr,
    input  wire                      register_read_command,
    input  wire                      register_write_command,
    input  wire [`ADCIS_DATA_W-1:0]  reg_wdata,
    output reg  [`ADCIS_DATA_W-1:0]  reg_rdata,
    output reg                       reg_rvalid,
    // Monitor enables from the configuration registers
    input  wire                      rail_monitor_enable,
    input  wire [1:0]                reference_monitor_enable,
    // Start-up state from the core
    input  wire                      device_not_ready,
    // Analog comparator outputs, asynchronous
    input  wire [`ADCIS_CMP_W-1:0]   cmp_raw,
    // Status view for the rest of the device
    output wire [`ADCIS_DATA_W-1:0]  status_flags
);

    wire [`ADCIS_CMP_W-1:0] cmp_sync;

    // Comparators toggle freely near a threshold, so each is synchronised alone
    genvar gi;
    generate
        for (gi = 0; gi < `ADCIS_CMP_W; gi = gi + 1) begin : g_sync
            adcis_sync2 u_sync (
                .ref_clk  (ref_clk),
                .sys_rst  (sys_rst),
                .async_in (cmp_raw[gi]),
                .sync_out (cmp_sync[gi])
            );
        end
    endgenerate

    function addr_hit;
        input [`ADCIS_ADDR_W-1:0] a;
        input [`ADCIS_ADDR_W-1:0] target;
        begin
            addr_hit = (a == target);
        end
    endfunction

    reg power_on_event_flag_q;
    reg power_on_event_flag_d;
    reg pos_out_near_high_rail_q;
    reg pos_out_near_low_rail_q;
    reg neg_out_near_high_rail_q;
    reg neg_out_near_low_rail_q;
    reg ref_below_third_supply_q;
    reg ref_below_floor_q;
    reg not_ready_q;

    wire status_wr = register_write_command & addr_hit(reg_addr, `ADCIS_ADDR_STATUS);

    // Reset or a host write to the status register with bit 7 high sets the flag; such a write with bit 7 low is the sole clear path
    always @* begin
        power_on_event_flag_d = power_on_event_flag_q;
        if (status_wr) begin
            power_on_event_flag_d = reg_wdata[`ADCIS_ST_POR];
        end
    end

    // Monitor flags follow their comparators and are forced low while disabled
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            power_on_event_flag_q    <= 1'b1;
            pos_out_near_high_rail_q <= 1'b0;
            pos_out_near_low_rail_q  <= 1'b0;
            neg_out_near_high_rail_q <= 1'b0;
            neg_out_near_low_rail_q  <= 1'b0;
            ref_below_third_supply_q <= 1'b0;
            ref_below_floor_q        <= 1'b0;
            not_ready_q              <= 1'b0;
        end else begin
            power_on_event_flag_q    <= power_on_event_flag_d;
            pos_out_near_high_rail_q <= rail_monitor_enable
                                        & cmp_sync[`ADCIS_CMP_POS_HIGH];
            pos_out_near_low_rail_q  <= rail_monitor_enable
                                        & cmp_sync[`ADCIS_CMP_POS_LOW];
            neg_out_near_high_rail_q <= rail_monitor_enable
                                        & cmp_sync[`ADCIS_CMP_NEG_HIGH];
            neg_out_near_low_rail_q  <= rail_monitor_enable
                                        & cmp_sync[`ADCIS_CMP_NEG_LOW];
            ref_below_third_supply_q <= reference_monitor_enable[`ADCIS_REFEN_THIRD]
                                        & cmp_sync[`ADCIS_CMP_REF_THIRD];
            ref_below_floor_q        <= reference_monitor_enable[`ADCIS_REFEN_FLOOR]
                                        & cmp_sync[`ADCIS_CMP_REF_FLOOR];
            not_ready_q              <= device_not_ready;
        end
    end

    assign status_flags = {power_on_event_flag_q,
                           not_ready_q,
                           pos_out_near_high_rail_q,
                           pos_out_near_low_rail_q,
                           neg_out_near_high_rail_q,
                           neg_out_near_low_rail_q,
                           ref_below_third_supply_q,
                           ref_below_floor_q};

    // Read data is registered; unmapped addresses read as zero
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata  <= `ADCIS_ZERO8;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= register_read_command;
            if (register_read_command) begin
                if (addr_hit(reg_addr, `ADCIS_ADDR_IDENT)) begin
                    reg_rdata <= {ID_RSVD, MODEL_CODE};
                end else if (addr_hit(reg_addr, `ADCIS_ADDR_STATUS)) begin
                    reg_rdata <= status_flags;
                end else begin
                    reg_rdata <= `ADCIS_ZERO8;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** test/adcis_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcis_chk #(
    parameter [2:0] MODEL_CODE = 3'h7,
    parameter [4:0] ID_RSVD    = 5'h00
) (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic       register_read_command,
    input wire logic       register_write_command,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       rail_monitor_enable,
    input wire logic [1:0] reference_monitor_enable,
    input wire logic       device_not_ready,
    input wire logic [7:0] status_flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire rd = register_read_command;
    wire ws = register_write_command && reg_addr == 8'h01;
    chk_read_strobe: assert property (rd |=> reg_rvalid)
        else $error("read not answered");
    chk_rvalid_cause: assert property (reg_rvalid |-> $past(rd))
        else $error("answer without read");
    chk_model_code: assert property (rd && reg_addr == 8'h00 |=> reg_rdata[2:0] == MODEL_CODE)
        else $error("bad model code");
    chk_ident_rsvd: assert property (rd && reg_addr == 8'h00 |=> reg_rdata[7:3] == ID_RSVD)
        else $error("bad ident read");
    chk_status_value: assert property (rd && reg_addr == 8'h01 |=> reg_rdata == $past(status_flags))
        else $error("status read mismatch");
    chk_unmapped_zero: assert property (rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_por_write: assert property (ws |=> status_flags[7] == $past(reg_wdata[7]))
        else $error("flag write lost");
    chk_por_sticky: assert property (!ws |=> $stable(status_flags[7]))
        else $error("flag changed without write");
    chk_ready_copy: assert property (!$past(sys_rst) |-> status_flags[6] == $past(device_not_ready))
        else $error("ready bit not copied");
    chk_rail_gate: assert property (!rail_monitor_enable |=> status_flags[5:2] == 4'h0)
        else $error("rail flag while disabled");
    chk_ref_gate: assert property (##1 (status_flags[1:0] & ~$past(reference_monitor_enable)) == 2'h0)
        else $error("reference flag while disabled");
endmodule
bind adcis_id_status_regs adcis_chk #(.MODEL_CODE(MODEL_CODE), .ID_RSVD(ID_RSVD)) u_chk (.*);
`default_nettype wire

// *** test/adcis_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcis_host (
    // Answer from the device
    input  wire logic       ref_clk,
    input  wire logic       reg_rvalid,
    input  wire logic [7:0] reg_rdata,
    // Requests to the device
    output var  logic [7:0] reg_addr,
    output var  logic       register_read_command,
    output var  logic       register_write_command,
    output var  logic [7:0] reg_wdata
);
    initial {reg_addr, reg_wdata, register_read_command, register_write_command} = 18'h0;
    // One-cycle command pulse; released data is inverted so it is never mistaken for held
    task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q,
                          output bit ok);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        register_read_command <= !w;
        register_write_command <= w;
        @(posedge ref_clk);
        register_read_command <= 1'b0;
        register_write_command <= 1'b0;
        reg_wdata <= ~d;
        ok = w;
        q = 8'h00;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge ref_clk);
            ok = reg_rvalid;
            q = reg_rdata;
        end
    endtask
endmodule
`default_nettype wire

// *** test/adcis_id_status_regs_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcis_id_status_regs_tb;
    logic ref_clk, sys_rst, register_read_command, register_write_command, reg_rvalid;
    logic rail_monitor_enable, device_not_ready;
    logic [1:0] reference_monitor_enable;
    logic [5:0] cmp_raw;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, status_flags, q;
    bit ok;
    int n_fail = 0;
    int num_checks = 0;
    adcis_host host (.*);
    adcis_id_status_regs #(.MODEL_CODE(3'h2)) dut (.*);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic compare(input string what, input logic [7:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, d);
        host.access(w, a, d, q, ok);
        if (!ok) begin
            n_fail++;
            complete_run;
        end
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        compare("status after reset", 8'h80, status_flags);
    endtask
    task automatic t_reads;
        xfer(0, 8'h00, 8'h00);
        compare("model code", 8'h02, q & 8'h07);
        xfer(0, 8'h01, 8'h00);
        compare("status read", 8'h80, q);
        xfer(0, 8'h05, 8'h00);
        compare("unmapped read", 8'h00, q);
    endtask
    task automatic t_por;
        xfer(1, 8'h00, 8'h00);
        xfer(0, 8'h01, 8'h00);
        compare("flag after stray write", 8'h80, q);
        xfer(1, 8'h01, 8'h7F);
        xfer(0, 8'h01, 8'h00);
        compare("flag after clear", 8'h00, q);
        do_reset;
    endtask
    task automatic t_ready;
        @(posedge ref_clk);
        device_not_ready <= 1'b1;
        repeat (2) @(negedge ref_clk);
        compare("not ready bit", 8'h40, status_flags & 8'h40);
        @(posedge ref_clk);
        device_not_ready <= 1'b0;
        repeat (2) @(negedge ref_clk);
        compare("ready bit", 8'h00, status_flags & 8'h40);
    endtask
    task automatic t_flags;
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            cmp_raw <= 6'h01 << i;
            repeat (4) @(negedge ref_clk);
            compare("monitor flag", 8'h20 >> i, status_flags & 8'h3F);
        end
        @(posedge ref_clk);
        cmp_raw <= 6'h3F;
        rail_monitor_enable <= 1'b0;
        reference_monitor_enable <= 2'h1;
        repeat (4) @(negedge ref_clk);
        compare("gated flags", 8'h01, status_flags & 8'h3F);
        @(posedge ref_clk);
        reference_monitor_enable <= 2'h2;
        repeat (2) @(negedge ref_clk);
        compare("gated flags", 8'h02, status_flags & 8'h3F);
    endtask
    initial begin
        {sys_rst, device_not_ready, cmp_raw} = 8'h80;
        rail_monitor_enable = 1'b1;
        reference_monitor_enable = 2'h3;
        do_reset;
        t_reads;
        t_por;
        t_ready;
        t_flags;
        complete_run;
    end
endmodule
`default_nettype wire
